/* core/tcc_core.sv */
// Three-channel 16-bit timer counter core with Avalon-MM register slave
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

module tcc_core
  import tcc_pkg::*;
(
  input  wire logic              I_MCLK,
  input  wire logic              I_RST,
  input  wire logic              I_SLOW_CLK,
  input  wire logic [2:0]        I_EXT_CLOCK_PIN,
  input  wire logic [2:0]        I_IO_LINE_A,
  input  wire logic [2:0]        I_IO_LINE_B,
  output logic      [2:0]        O_IO_LINE_A,
  output logic      [2:0]        O_IO_LINE_A_OE,
  output logic      [2:0]        O_IRQ,
  input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [31:0]       I_AVS_WRITEDATA,
  input  wire logic [3:0]        I_AVS_BYTEENABLE,
  output logic      [31:0]       O_AVS_READDATA,
  output logic                   O_AVS_WAITREQUEST
);

  //////////////////////////////////////////////////////////////////////////
  // Helper functions

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] cmr_word(input tcc_chan_t c);
    cmr_word = 32'h0000_0000;
    cmr_word[CMR_CLKS +: 3]  = c.clks;
    cmr_word[CMR_CLOCK_INVERT_BIT]       = c.clock_invert_bit;
    cmr_word[CMR_BURST +: 2] = c.burst;
    cmr_word[CMR_WAVE]       = c.wave;
  endfunction

  function automatic logic [31:0] sr_word(input tcc_chan_t c);
    sr_word = 32'h0000_0000;
    sr_word[SR_COVF]   = c.covf;
    sr_word[SR_TRG]    = c.trg_flag;
    sr_word[SR_CLKSTA] = c.clken;
  endfunction

  // Level of the selected source before inversion
  function automatic logic src_level(
    input logic [2:0]         clks,
    input logic [PRESC_W-1:0] presc,
    input logic               slow,
    input logic [2:0]         xc
  );
    case (clks)
      CLKS_DIV2:   src_level = presc[TAP_DIV2];
      CLKS_DIV8:   src_level = presc[TAP_DIV8];
      CLKS_DIV32:  src_level = presc[TAP_DIV32];
      CLKS_DIV128: src_level = presc[TAP_DIV128];
      CLKS_SLOW:   src_level = slow;
      CLKS_XC0:    src_level = xc[0];
      CLKS_XC1:    src_level = xc[1];
      default:     src_level = xc[2];
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State and combinational temporaries

  tcc_state_t       st_reg;
  tcc_state_t       st_next;

  logic [31:0]      be_mask;
  logic [31:0]      wd;
  logic             acc_wr;
  logic [1:0]       sel;
  logic [5:0]       ofs;
  logic             sync_p;
  logic [2:0]       xc;
  logic             q_change;
  logic             q_up;
  logic [NCH-1:0]   lvl;
  logic [NCH-1:0]   gate;
  logic [NCH-1:0]   step;
  logic [NCH-1:0]   up;
  logic [NCH-1:0]   trig;
  logic [NCH-1:0]   ch_wr;
  logic [31:0]      cmr_m;

  always_comb begin
    st_next  = st_reg;
    be_mask  = lane_mask(I_AVS_BYTEENABLE);
    wd       = I_AVS_WRITEDATA & be_mask;
    acc_wr   = (st_reg.phase == TCC_ACK) && I_AVS_WRITE;
    sel      = I_AVS_ADDRESS[7:6];
    ofs      = I_AVS_ADDRESS[5:0];
    cmr_m    = 32'h0000_0000;
    lvl      = '0;
    gate     = '0;
    step     = '0;
    up       = '0;
    trig     = '0;
    ch_wr    = '0;

    // Free-running prescaler for the divided taps
    st_next.presc = st_reg.presc + 7'h01;

    // Two-flop synchronisers on every asynchronous input
    st_next.pin_s1  = I_EXT_CLOCK_PIN;
    st_next.pin_s2  = st_reg.pin_s1;
    st_next.la_s1   = I_IO_LINE_A;
    st_next.la_s2   = st_reg.la_s1;
    st_next.lb_s1   = I_IO_LINE_B;
    st_next.lb_s2   = st_reg.lb_s1;
    st_next.slow_s1 = I_SLOW_CLK;
    st_next.slow_s2 = st_reg.slow_s1;

    // External selection n: pin n or line A of the next channel
    for (int n = 0; n < NCH; n++) begin
      xc[n] = st_reg.xc_line_a[n] ? st_reg.la_s2[(n + 1) % NCH]
                                  : st_reg.pin_s2[n];
    end

    // Quadrature decode of line A0 / line B0, index on line B1
    q_change = (st_reg.la_s2[0] ^ st_reg.qa_prev)
             ^ (st_reg.lb_s2[0] ^ st_reg.qb_prev);
    q_up     = ~(st_reg.qa_prev ^ st_reg.lb_s2[0]);
    st_next.qa_prev = st_reg.la_s2[0];
    st_next.qb_prev = st_reg.lb_s2[0];
    st_next.qi_prev = st_reg.lb_s2[1];

    //////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, action at the accepting edge

    case (st_reg.phase)
      TCC_IDLE: begin
        if (I_AVS_READ || I_AVS_WRITE) begin
          st_next.phase   = TCC_ACK;
          st_next.waitreq = 1'b0;
          st_next.rdata   = 32'h0000_0000;
          if (I_AVS_READ && sel != BLK_SEL && sel < 2'(NCH)) begin
            case (ofs)
              OFS_CMR: st_next.rdata = cmr_word(st_reg.ch[sel]);
              OFS_CV:  st_next.rdata = {16'h0000,
                                        st_reg.ch[sel].count};
              OFS_SR:  st_next.rdata = sr_word(st_reg.ch[sel]);
              OFS_IMR: st_next.rdata = {30'h0, st_reg.ch[sel].mask};
              default: st_next.rdata = 32'h0000_0000;
            endcase
          end else if (I_AVS_READ && sel == BLK_SEL && ofs == OFS_BMR) begin
            st_next.rdata[BMR_XC +: 3] = st_reg.xc_line_a;
            st_next.rdata[BMR_QUADRATURE_DECODER]    = st_reg.quadrature_decoder_en;
          end
        end
      end
      TCC_ACK: begin
        st_next.phase   = TCC_IDLE;
        st_next.waitreq = 1'b1;
      end
      default: begin
        st_next.phase   = TCC_IDLE;
        st_next.waitreq = 1'b1;
      end
    endcase

    // Block registers
    sync_p = acc_wr && sel == BLK_SEL && ofs == OFS_BCR
             && wd[BCR_SYNC];
    if (acc_wr && sel == BLK_SEL && ofs == OFS_BMR) begin
      if (I_AVS_BYTEENABLE[0]) begin
        st_next.xc_line_a = wd[BMR_XC +: 3];
      end
      if (I_AVS_BYTEENABLE[1]) begin
        st_next.quadrature_decoder_en = wd[BMR_QUADRATURE_DECODER];
      end
    end

    //////////////////////////////////////////////////////////////////////
    // Channels

    for (int i = 0; i < NCH; i++) begin
      ch_wr[i] = acc_wr && sel == 2'(i);

      // Mode register with byte-lane merge
      if (ch_wr[i] && ofs == OFS_CMR) begin
        cmr_m = (cmr_word(st_reg.ch[i]) & ~be_mask) | wd;
        st_next.ch[i].clks  = cmr_m[CMR_CLKS +: 3];
        st_next.ch[i].clock_invert_bit  = cmr_m[CMR_CLOCK_INVERT_BIT];
        st_next.ch[i].burst = cmr_m[CMR_BURST +: 2];
        st_next.ch[i].wave  = cmr_m[CMR_WAVE];
      end
      if (ch_wr[i] && ofs == OFS_IMR) begin
        st_next.ch[i].mask = wd[1:0];
      end

      // Enable and disable, disable winning
      if (ch_wr[i] && ofs == OFS_CCR && wd[CCR_CLKEN]) begin
        st_next.ch[i].clken = 1'b1;
      end
      if (ch_wr[i] && ofs == OFS_CCR && wd[CCR_CLKDIS]) begin
        st_next.ch[i].clken   = 1'b0;
        st_next.ch[i].started = 1'b0;
      end

      // Software or sync trigger, only while the clock is enabled
      trig[i] = (ch_wr[i] && ofs == OFS_CCR && wd[CCR_SWTRG]) || sync_p;
      if (trig[i] && st_next.ch[i].clken) begin
        st_next.ch[i].started  = 1'b1;
        st_next.ch[i].trg_pend = 1'b1;
      end

      // Counting edge: select, invert, detect, gate
      lvl[i] = src_level(st_reg.ch[i].clks, st_reg.presc,
                         st_reg.slow_s2, xc)
               ^ st_reg.ch[i].clock_invert_bit;
      st_next.ch[i].lvl_prev = lvl[i];
      gate[i] = (st_reg.ch[i].burst == BURST_NONE)
                || xc[st_reg.ch[i].burst - 2'h1];
      step[i] = lvl[i] && !st_reg.ch[i].lvl_prev && gate[i];
      up[i]   = 1'b1;

      // Decoder takes over the counting edges of channels 0 and 1
      if (st_reg.quadrature_decoder_en && i == 0) begin
        step[i] = q_change;
        up[i]   = q_up;
      end else if (st_reg.quadrature_decoder_en && i == 1) begin
        step[i] = st_reg.lb_s2[1] && !st_reg.qi_prev;
      end

      // Clear by writing one; an event set below in the same cycle wins
      if (ch_wr[i] && ofs == OFS_SR && wd[SR_COVF]) begin
        st_next.ch[i].covf = 1'b0;
      end
      if (ch_wr[i] && ofs == OFS_SR && wd[SR_TRG]) begin
        st_next.ch[i].trg_flag = 1'b0;
      end

      if (step[i] && st_reg.ch[i].clken && st_reg.ch[i].started) begin
        if (st_reg.ch[i].trg_pend) begin
          st_next.ch[i].count    = 16'h0000;
          st_next.ch[i].trg_pend = 1'b0;
          st_next.ch[i].trg_flag = 1'b1;
        end else if (up[i]) begin
          st_next.ch[i].count = st_reg.ch[i].count + 16'h0001;
          if (st_reg.ch[i].count == CNT_MAX) begin
            st_next.ch[i].covf = 1'b1;
          end
        end else begin
          st_next.ch[i].count = st_reg.ch[i].count - 16'h0001;
        end
      end

      // Line A drives a square wave in waveform mode only
      st_next.ch[i].line_a_oe  = st_next.ch[i].wave;
      st_next.ch[i].line_a_out = st_next.ch[i].wave
                                 && st_next.ch[i].count[15];

      st_next.ch[i].irq = |({st_next.ch[i].trg_flag,
                             st_next.ch[i].covf}
                            & st_next.ch[i].mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      st_reg         <= '0;
      st_reg.phase   <= TCC_IDLE;
      st_reg.waitreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    O_AVS_READDATA    = st_reg.rdata;
    O_AVS_WAITREQUEST = st_reg.waitreq;
    for (int k = 0; k < NCH; k++) begin
      O_IO_LINE_A[k]    = st_reg.ch[k].line_a_out;
      O_IO_LINE_A_OE[k] = st_reg.ch[k].line_a_oe;
      O_IRQ[k]          = st_reg.ch[k].irq;
    end
  end

endmodule

/* core/tcc_pkg.sv */
// Constants, types and register map of the timer counter clocking core
// Operation
// - Three identical channels, each programmed on its own.
// - A 16-bit counter per channel steps on selected clock rising edges.
// - Wrap from all ones to zero sets the channel overflow flag.
// - Counter value readable at any time without stopping the counter.
// - A trigger zeroes the counter at the next valid counting edge.
// - Clock select picks one of three external or five internal sources.
// - Block mode routes each external selection to its pin or a line A.
// - Clock invert bit makes counting happen on opposite source edges.
// - Burst gating passes counting edges only while its signal is high.
// - Each channel drives one interrupt from programmable status events.
// - One block control write synchronises all channels together.
// - Channels independent unless the decoder uses line A0, B0 and B1.
// - Line A input in capture, output in waveform; line B input.
// - Any trigger starts the clock, only while the clock is enabled.
// - Wave mode bit clear selects capture mode, set selects waveform mode.
package tcc_pkg;

  localparam int NCH = 3;

  // Address decode: bits 7:6 select channel or block area
  localparam int          ADDR_W   = 8;
  localparam logic [1:0]  BLK_SEL  = 2'h3;
  localparam logic [5:0]  OFS_CCR  = 6'h00;
  localparam logic [5:0]  OFS_CMR  = 6'h04;
  localparam logic [5:0]  OFS_CV   = 6'h10;
  localparam logic [5:0]  OFS_SR   = 6'h20;
  localparam logic [5:0]  OFS_IMR  = 6'h2c;
  localparam logic [5:0]  OFS_BCR  = 6'h00;
  localparam logic [5:0]  OFS_BMR  = 6'h04;

  // Field positions
  localparam int CCR_CLKEN  = 0;
  localparam int CCR_CLKDIS = 1;
  localparam int CCR_SWTRG  = 2;
  localparam int CMR_CLKS   = 0;
  localparam int CMR_CLOCK_INVERT_BIT   = 3;
  localparam int CMR_BURST  = 4;
  localparam int CMR_WAVE   = 15;
  localparam int SR_COVF    = 0;
  localparam int SR_TRG     = 1;
  localparam int SR_CLKSTA  = 16;
  localparam int BCR_SYNC   = 0;
  localparam int BMR_XC     = 0;
  localparam int BMR_QUADRATURE_DECODER   = 8;

  // Clock select codes
  localparam logic [2:0] CLKS_DIV2   = 3'h0;
  localparam logic [2:0] CLKS_DIV8   = 3'h1;
  localparam logic [2:0] CLKS_DIV32  = 3'h2;
  localparam logic [2:0] CLKS_DIV128 = 3'h3;
  localparam logic [2:0] CLKS_SLOW   = 3'h4;
  localparam logic [2:0] CLKS_XC0    = 3'h5;
  localparam logic [2:0] CLKS_XC1    = 3'h6;

  // Prescaler bit that forms each divided tap
  localparam int PRESC_W    = 7;
  localparam int TAP_DIV2   = 0;
  localparam int TAP_DIV8   = 2;
  localparam int TAP_DIV32  = 4;
  localparam int TAP_DIV128 = 6;

  localparam logic [1:0]  BURST_NONE = 2'h0;
  localparam logic [15:0] CNT_MAX    = 16'hffff;

  typedef enum logic [0:0] {TCC_IDLE, TCC_ACK} tcc_bus_t;

  typedef struct packed {
    logic [15:0] count;
    logic        clken;
    logic        started;
    logic        trg_pend;
    logic        covf;
    logic        trg_flag;
    logic [1:0]  mask;
    logic [2:0]  clks;
    logic        clock_invert_bit;
    logic [1:0]  burst;
    logic        wave;
    logic        lvl_prev;
    logic        line_a_out;
    logic        line_a_oe;
    logic        irq;
  } tcc_chan_t;

  typedef struct packed {
    tcc_bus_t               phase;
    logic                   waitreq;
    logic [31:0]            rdata;
    logic [PRESC_W-1:0]     presc;
    logic [2:0]             pin_s1;
    logic [2:0]             pin_s2;
    logic [2:0]             la_s1;
    logic [2:0]             la_s2;
    logic [2:0]             lb_s1;
    logic [2:0]             lb_s2;
    logic                   slow_s1;
    logic                   slow_s2;
    logic [2:0]             xc_line_a;
    logic                   quadrature_decoder_en;
    logic                   qa_prev;
    logic                   qb_prev;
    logic                   qi_prev;
    tcc_chan_t [NCH-1:0]    ch;
  } tcc_state_t;

endpackage

/* verif/tb.sv */
// Self-checking bench of the timer counter core
`timescale 1ns/1ps
module tb;
  import tcc_pkg::*;
  logic              mclk = 1'b0;
  logic              rst  = 1'b1;
  logic [ADDR_W-1:0] adr  = 8'h0;
  logic              rd   = 1'b0;
  logic              wr   = 1'b0;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       rdat;
  logic [31:0]       rdata;
  logic              wreq;
  logic [5:0]        run  = 6'h0;
  logic [5:0]        lvl;
  logic              slow;
  logic [2:0]        la;
  logic [2:0]        la_oe;
  logic [2:0]        irq;
  int                edges [6];
  int                bad_count = 0;
  int                compares  = 0;
  int                dv [5]    = '{2, 8, 32, 128, 16};
  logic [5:0]        ofs [4]   = '{OFS_CMR, OFS_CV, OFS_SR, OFS_IMR};

  always #12.5 mclk = ~mclk;

  tcc_core i_dut (
    .I_MCLK(mclk), .I_RST(rst), .I_SLOW_CLK(slow),
    .I_EXT_CLOCK_PIN(lvl[2:0]), .I_IO_LINE_A(lvl[5:3]),
    .I_IO_LINE_B({lvl[5:4], lvl[0]}), .O_IO_LINE_A(la),
    .O_IO_LINE_A_OE(la_oe), .O_IRQ(irq), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq)
  );
  tcc_ext_model #(.HALF(4), .SLOW_HALF(8)) i_ext (
    .i_clk(mclk), .i_run(run), .o_lvl(lvl), .o_slow(slow), .o_edges(edges)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rng(input logic [31:0] g, input int lo, input int hi);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %h not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    adr  <= a;
    wdat <= d;
    rd   <= ~w;
    wr   <= w;
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic put(input logic [1:0] c, input logic [5:0] o,
                     input logic [31:0] d);
    bus(1'b1, {c, o}, d);
  endtask
  task automatic get(input logic [1:0] c, input logic [5:0] o,
                     input logic [31:0] e);
    bus(1'b0, {c, o}, 32'h0);
    chk(rdat, e);
  endtask
  function automatic int rises(input logic s, input int e);
    return s ? e / 2 : (e + 1) / 2;
  endfunction
  // Run one far-side source for e level changes, then let it stand
  task automatic move(input int i, input int e);
    int s = edges[i];
    @(posedge mclk);
    run[i] <= 1'b1;
    while (edges[i] < s + e) begin
      @(posedge mclk);
    end
    run[i] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    for (int c = 0; c < 3; c++) begin
      foreach (ofs[k]) begin
        get(c[1:0], ofs[k], 32'h0);
      end
    end
    get(BLK_SEL, OFS_BMR, 32'h0);
    put(2'h0, 6'h08, 32'hffff);
    get(2'h0, 6'h08, 32'h0);
    get(BLK_SEL, 6'h10, 32'h0);
  endtask
  task automatic s_taps();
    logic [31:0] v;
    for (int k = 0; k < 5; k++) begin
      put(2'h1, OFS_CMR, k);
      put(2'h1, OFS_CCR, 32'h5);
      repeat (512) @(posedge mclk);
      bus(1'b0, {2'h1, OFS_CV}, 32'h0);
      v = rdat;
      rng(v, 512 / dv[k] - 3, 512 / dv[k] + 1);
      bus(1'b0, {2'h1, OFS_CV}, 32'h0);
      rng(rdat, v + (k == 0), v + 2);
    end
    put(2'h1, OFS_CCR, 32'h2);
  endtask
  task automatic s_ext();
    logic        s;
    logic [31:0] v;
    for (int c = 0; c < 3; c++) begin
      put(c[1:0], OFS_CMR, 5 + c);
      put(c[1:0], OFS_CCR, 32'h5);
      s = lvl[c];
      move(c, 7);
      get(c[1:0], OFS_CV, rises(s, 7) - 1);
    end
    put(2'h0, OFS_CMR, 32'hd);
    put(2'h0, OFS_CCR, 32'h4);
    s = lvl[0];
    move(0, 7);
    get(2'h0, OFS_CV, 6 - rises(s, 7));
    put(2'h0, OFS_SR, 32'h3);
    bus(1'b0, {2'h0, OFS_CV}, 32'h0);
    v = rdat;
    put(2'h0, OFS_CCR, 32'h4);
    get(2'h0, OFS_CV, v);
    get(2'h0, OFS_SR, 32'h10000);
    move(0, 2);
    get(2'h0, OFS_CV, 32'h0);
    get(2'h0, OFS_SR, 32'h10002);
    put(BLK_SEL, OFS_BMR, 32'h1);
    put(2'h0, OFS_CMR, 32'h5);
    put(2'h0, OFS_CCR, 32'h4);
    move(4, 6);
    get(2'h0, OFS_CV, 32'h2);
    move(0, 6);
    get(2'h0, OFS_CV, 32'h2);
    put(BLK_SEL, OFS_BMR, 32'h0);
  endtask
  // Decoder: channel 0 up and down on line A0 / B0, channel 1 on B1 rises
  task automatic s_quadrature_decoder();
    put(BLK_SEL, OFS_BMR, 32'h100);
    put(2'h0, OFS_SR, 32'h3);
    put(2'h0, OFS_CCR, 32'h4);
    put(2'h1, OFS_CCR, 32'h4);
    move(3, 1);
    move(3, 1);
    get(2'h0, OFS_CV, 32'hffff);
    move(3, 1);
    get(2'h0, OFS_CV, 32'h0);
    get(2'h0, OFS_SR, 32'h10003);
    move(4, 4);
    get(2'h1, OFS_CV, 32'h1);
    put(BLK_SEL, OFS_BMR, 32'h0);
  endtask
  task automatic s_burst();
    logic [31:0] v;
    for (int b = 1; b < 4; b++) begin
      if (lvl[b - 1] === 1'b1) begin
        move(b - 1, 1);
      end
      put(2'h2, OFS_CMR, 32'h1 | (b << 4));
      put(2'h2, OFS_CCR, 32'h5);
      bus(1'b0, {2'h2, OFS_CV}, 32'h0);
      v = rdat;
      repeat (200) @(posedge mclk);
      get(2'h2, OFS_CV, v);
      move(b - 1, 1);
      repeat (400) @(posedge mclk);
      bus(1'b0, {2'h2, OFS_CV}, 32'h0);
      rng(rdat, 46, 53);
      move(b - 1, 1);
    end
  endtask
  task automatic s_irq();
    put(2'h1, OFS_CMR, 32'h0);
    put(2'h1, OFS_SR, 32'h3);
    put(2'h1, OFS_IMR, 32'h2);
    repeat (2) @(posedge mclk);
    chk(irq, 3'h0);
    put(2'h1, OFS_CCR, 32'h5);
    repeat (8) @(posedge mclk);
    chk(irq, 3'h2);
    put(2'h1, OFS_IMR, 32'h0);
    repeat (2) @(posedge mclk);
    chk(irq, 3'h0);
    put(2'h1, OFS_IMR, 32'h2);
    repeat (2) @(posedge mclk);
    chk(irq, 3'h2);
    put(2'h1, OFS_SR, 32'h2);
    repeat (2) @(posedge mclk);
    chk(irq, 3'h0);
    put(2'h1, OFS_CCR, 32'h2);
  endtask
  task automatic s_sync();
    logic [31:0] v;
    for (int c = 0; c < 3; c++) begin
      put(c[1:0], OFS_CMR, 32'h0);
      put(c[1:0], OFS_CCR, 32'h2);
      put(c[1:0], OFS_SR, 32'h3);
    end
    put(BLK_SEL, OFS_BCR, 32'h1);
    get(2'h2, OFS_SR, 32'h0);
    for (int c = 0; c < 3; c++) begin
      put(c[1:0], OFS_CCR, 32'h1);
    end
    bus(1'b0, {2'h0, OFS_CV}, 32'h0);
    v = rdat;
    repeat (20) @(posedge mclk);
    get(2'h0, OFS_CV, v);
    put(BLK_SEL, OFS_BCR, 32'h1);
    repeat (40) @(posedge mclk);
    for (int c = 0; c < 3; c++) begin
      get(c[1:0], OFS_SR, 32'h10002);
    end
    bus(1'b0, {2'h0, OFS_CV}, 32'h0);
    v = rdat;
    bus(1'b0, {2'h1, OFS_CV}, 32'h0);
    rng(rdat - v, 1, 2);
  endtask
  task automatic s_wave();
    put(2'h0, OFS_CMR, 32'h8000);
    repeat (3) @(posedge mclk);
    chk(la_oe, 3'h1);
    put(2'h0, OFS_CMR, 32'h0);
    repeat (3) @(posedge mclk);
    chk(la_oe, 3'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    s_regs();
    s_taps();
    s_ext();
    s_quadrature_decoder();
    s_burst();
    s_irq();
    s_sync();
    s_wave();
    do_reset();
    s_regs();
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    complete_run();
  end
endmodule

/* verif/tcc_checker.sv */
// Bus, interrupt and line A checks of the timer counter core
`timescale 1ns/1ps
module tcc_checker
  import tcc_pkg::*;
(
  input wire logic              I_MCLK,
  input wire logic              I_RST,
  input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic              I_AVS_READ,
  input wire logic              I_AVS_WRITE,
  input wire logic [31:0]       O_AVS_READDATA,
  input wire logic              O_AVS_WAITREQUEST,
  input wire logic [2:0]        O_IRQ,
  input wire logic [2:0]        O_IO_LINE_A,
  input wire logic [2:0]        O_IO_LINE_A_OE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  logic [2:0] mask_seen;
  logic       req;
  logic       rdok;
  logic [5:0] ofs;
  assign req  = I_AVS_READ || I_AVS_WRITE;
  assign ofs  = I_AVS_ADDRESS[5:0];
  assign rdok = ofs == OFS_CMR || (I_AVS_ADDRESS[7:6] != BLK_SEL &&
                (ofs == OFS_CV || ofs == OFS_SR || ofs == OFS_IMR));
  // Channels whose mask was ever written
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      mask_seen <= 3'h0;
    end else if (I_AVS_WRITE && !O_AVS_WAITREQUEST && ofs == OFS_IMR &&
                 I_AVS_ADDRESS[7:6] != BLK_SEL) begin
      mask_seen[I_AVS_ADDRESS[7:6]] <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_ack_once;
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_due;
    req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack missing");
  property p_idle;
    !req |=> O_AVS_WAITREQUEST;
  endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_refused;
    I_AVS_READ && O_AVS_WAITREQUEST && !rdok |=> O_AVS_READDATA == 32'h0;
  endproperty
  a_refused: assert property (p_refused) else $error("unmapped read data");
  property p_line_quiet;
    (O_IO_LINE_A & ~O_IO_LINE_A_OE) == 3'h0;
  endproperty
  a_line_quiet: assert property (p_line_quiet)
    else $error("line A value while not driven");
  property p_oe_cause;
    $changed(O_IO_LINE_A_OE) |-> $past(I_AVS_WRITE) ||
      $past(I_AVS_WRITE, 2) || $past(I_AVS_WRITE, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("line A enable moved without a write");
  property p_irq_drop;
    ($past(O_IRQ) & ~O_IRQ) != 3'h0 |-> $past(I_AVS_WRITE) ||
      $past(I_AVS_WRITE, 2) || $past(I_AVS_WRITE, 3);
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("interrupt dropped without a write");
  property p_irq_mask;
    (O_IRQ & ~mask_seen) == 3'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt while masked");
  c_irq: cover property ($rose(O_IRQ[1]));
  c_oe: cover property ($rose(O_IO_LINE_A_OE[0]));
  c_rd: cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
endmodule

bind tcc_core tcc_checker i_chk (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_IRQ(O_IRQ), .O_IO_LINE_A(O_IO_LINE_A), .O_IO_LINE_A_OE(O_IO_LINE_A_OE)
);

/* verif/tcc_ext_model.sv */
// Far-side model: external clock pins, line A pads and slow clock
`timescale 1ns/1ps
module tcc_ext_model #(
  parameter int HALF      = 4,
  parameter int SLOW_HALF = 8
) (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_run,
  output logic      [5:0] o_lvl,
  output logic            o_slow,
  output int              o_edges [6]
);
  int cnt [6];
  int scnt;
  initial begin
    o_lvl = 6'h0;
    o_slow = 1'b0;
    scnt = 0;
    for (int i = 0; i < 6; i++) begin
      cnt[i] = 0;
      o_edges[i] = 0;
    end
  end
  // Each level lasts HALF cycles, well under a third of the rate
  always @(posedge i_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (!i_run[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] == HALF - 1) begin
        cnt[i] <= 0;
        o_lvl[i] <= ~o_lvl[i];
        o_edges[i] <= o_edges[i] + 1;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
    scnt <= (scnt == SLOW_HALF - 1) ? 0 : scnt + 1;
    if (scnt == SLOW_HALF - 1) begin
      o_slow <= ~o_slow;
    end
  end
endmodule
